// ---- swfd_status_word.sv ----
`timescale 1ns/1ns
module swfd_status_word
    import swfd_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   nrst_i,
    input  wire logic                   ce_i,
    // Status instruction strobes
    input  wire logic                   load_status_word_op_i,
    input  wire logic [31:0]            status_data_i,
    input  wire logic                   acc_to_keys_op_i,
    input  wire logic                   output_keys_op_i,
    input  wire logic [15:0]            acc_i,
    input  wire logic                   keys_to_acc_op_i,
    output logic      [15:0]            acc_keys_o,
    // Process exchange
    input  wire logic                   px_write_i,
    input  wire logic                   px_dispatcher_i,
    input  wire logic                   px_save_done_i,
    input  wire logic [2:0]             px_register_set_i,
    // Arithmetic result
    input  wire logic                   result_valid_i,
    input  wire logic                   result_is_skip_op_i,
    input  wire logic                   result_carry_i,
    input  wire logic                   result_zero_i,
    input  wire logic                   result_ext_sign_i,
    // Exceptions
    input  wire logic                   arith_error_i,
    input  wire logic                   fp_exc_i,
    input  wire logic                   int_exc_i,
    input  wire logic                   dec_exc_i,
    output logic                        fault_o,
    // Status outputs
    output logic      [15:0]            status_keys_o,
    output logic      [15:0]            processor_modals_o,
    output logic      [2:0]             addr_mode_o,
    output logic                        virtual_mode_o,
    output logic                        precision_select_o,
    output logic                        interrupt_enable_o,
    output logic      [2:0]             active_register_set_o,
    // Instruction decode
    input  wire logic                   decode_load_i,
    input  wire swfd_pkg::swfd_fmt_type decode_fmt_i,
    input  wire logic [15:0]            decode_word_i,
    input  wire logic [31:0]            decode_ext_i,
    input  wire logic [15:0]            proc_base_i,
    output logic      [15:0]            opcode_o,
    output logic      [5:0]             shift_count_o,
    output swfd_pkg::swfd_io_class_type io_class_o,
    output logic      [3:0]             io_function_o,
    output logic      [5:0]             io_device_o,
    output logic      [31:0]            address_pointer_field_o,
    output logic      [15:0]            branch_target_o,
    output logic                        uses_field_regs_o,
    output logic                        uses_control_word_o,
    output logic                        format_error_o
);
    import swfd_pkg::*;

    // ------------------------------------------------------------
    // Status registers
    // ------------------------------------------------------------
    logic [15:0] keys_r,   keys_nxt;
    logic [15:0] modals_r, modals_nxt;
    logic        fault_r,  fault_nxt;
    logic [15:0] acc_r,    acc_nxt;
    logic        is_virt;
    logic [15:0] kmask;
    logic [15:0] sw_keys;
    logic        err_event;

    assign is_virt = (keys_r[KEY_MODE_H:KEY_MODE_L] == VIRTUAL64_MODE);
    assign kmask   = is_virt ? KEYS_V_WMASK : KEYS_SR_WMASK;

    always_comb
    begin
        keys_nxt   = keys_r;
        modals_nxt = modals_r;
        fault_nxt  = 1'b0;
        acc_nxt    = acc_r;
        sw_keys    = 16'h0000;
        err_event  = arith_error_i;
        // Software loads, exchange bits preserved
        if (load_status_word_op_i)
        begin
            keys_nxt   = (keys_r & ~kmask) | (status_data_i[31:16] & kmask);
            modals_nxt = (modals_r & ~MODALS_WMASK)
                       | (status_data_i[15:0] & MODALS_WMASK);
        end
        else if (acc_to_keys_op_i || output_keys_op_i)
        begin
            sw_keys  = acc_i;
            keys_nxt = (keys_r & ~kmask) | (sw_keys & kmask);
        end
        if (keys_to_acc_op_i)
            acc_nxt = keys_r;
        // Process exchange owns dispatcher, save-done and register set
        if (px_write_i)
        begin
            keys_nxt[KEY_DISP]  = px_dispatcher_i;
            keys_nxt[KEY_SAVED] = px_save_done_i;
            modals_nxt[MOD_RSET_H:MOD_RSET_L] = px_register_set_i;
        end
        // Condition codes and link from results
        if (result_valid_i)
        begin
            if (!result_is_skip_op_i)
                keys_nxt[KEY_LINK] = result_carry_i;
            if (is_virt)
            begin
                keys_nxt[KEY_ZERO] = result_zero_i;
                keys_nxt[KEY_NEG]  = result_ext_sign_i;
            end
        end
        // Exception routing
        if (is_virt)
        begin
            if (fp_exc_i)
            begin
                if (keys_r[KEY_FPX])
                    err_event = 1'b1;
                else
                    fault_nxt = 1'b1;
            end
            if (int_exc_i)
            begin
                if (keys_r[KEY_INTX])
                    fault_nxt = 1'b1;
                else
                    err_event = 1'b1;
            end
            if (dec_exc_i)
            begin
                if (keys_r[KEY_DECX])
                    fault_nxt = 1'b1;
                else
                    err_event = 1'b1;
            end
        end
        // Error event wins over a software clear
        if (err_event)
            keys_nxt[KEY_ERR] = 1'b1;
        // Layout follows the mode being entered; exchange bits survive mode changes
        keys_nxt   = keys_nxt & ((keys_nxt[KEY_MODE_H:KEY_MODE_L] == VIRTUAL64_MODE)
                   ? (KEYS_V_WMASK | KEYS_V_PX) : (KEYS_SR_WMASK | KEYS_V_PX));
        modals_nxt = modals_nxt & (MODALS_WMASK | MODALS_PX);
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            keys_r   <= KEYS_RST;
            modals_r <= MODALS_RST;
            fault_r  <= 1'b0;
            acc_r    <= 16'h0000;
        end
        else if (ce_i)
        begin
            keys_r   <= keys_nxt;
            modals_r <= modals_nxt;
            fault_r  <= fault_nxt;
            acc_r    <= acc_nxt;
        end
    end

    assign status_keys_o         = keys_r;
    assign processor_modals_o    = modals_r;
    assign acc_keys_o            = acc_r;
    assign fault_o               = fault_r;
    assign addr_mode_o           = keys_r[KEY_MODE_H:KEY_MODE_L];
    assign virtual_mode_o        = is_virt;
    assign precision_select_o    = keys_r[KEY_PREC];
    assign interrupt_enable_o    = modals_r[MOD_IEN];
    assign active_register_set_o = modals_r[MOD_RSET_H:MOD_RSET_L];

    // ------------------------------------------------------------
    // Instruction format decode
    // ------------------------------------------------------------
    swfd_format_decode u_decode (
        .clk_i                   (clk_i),
        .nrst_i                  (nrst_i),
        .ce_i                    (ce_i),
        .load_i                  (decode_load_i),
        .fmt_i                   (decode_fmt_i),
        .word1_i                 (decode_word_i),
        .ext_i                   (decode_ext_i),
        .proc_base_i             (proc_base_i),
        .opcode_o                (opcode_o),
        .shift_count_o           (shift_count_o),
        .io_class_o              (io_class_o),
        .io_function_o           (io_function_o),
        .io_device_o             (io_device_o),
        .address_pointer_field_o (address_pointer_field_o),
        .branch_target_o         (branch_target_o),
        .uses_field_regs_o       (uses_field_regs_o),
        .uses_control_word_o     (uses_control_word_o),
        .format_error_o          (format_error_o)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_err_set;
        @(posedge clk_i) disable iff (!nrst_i)
        (ce_i && arith_error_i) |=> keys_r[KEY_ERR];
    endproperty
    a_err_set: assert property (p_err_set) else $error("error flag not set");

    property p_keys_load;
        @(posedge clk_i) disable iff (!nrst_i)
        (ce_i && acc_to_keys_op_i && !load_status_word_op_i && !px_write_i
         && !result_valid_i && !arith_error_i && !fp_exc_i && !int_exc_i && !dec_exc_i
         && is_virt && acc_i[KEY_MODE_H:KEY_MODE_L] == VIRTUAL64_MODE)
        |=> keys_r == (($past(keys_r) & KEYS_V_PX) | ($past(acc_i) & KEYS_V_WMASK));
    endproperty
    a_keys_load: assert property (p_keys_load) else $error("keys transfer wrong");

    property p_ce_hold;
        @(posedge clk_i) disable iff (!nrst_i)
        !ce_i |=> $stable(keys_r) && $stable(modals_r) && $stable(acc_r);
    endproperty
    a_ce_hold: assert property (p_ce_hold) else $error("state moved while frozen");

    property p_fp_fault;
        @(posedge clk_i) disable iff (!nrst_i)
        (ce_i && is_virt && fp_exc_i && !keys_r[KEY_FPX]) |=> fault_o;
    endproperty
    a_fp_fault: assert property (p_fp_fault) else $error("fp fault missing");

    property p_int_fault;
        @(posedge clk_i) disable iff (!nrst_i)
        (ce_i && is_virt && int_exc_i && keys_r[KEY_INTX]) |=> fault_o;
    endproperty
    a_int_fault: assert property (p_int_fault) else $error("int fault missing");

    property p_dec_flag;
        @(posedge clk_i) disable iff (!nrst_i)
        (ce_i && is_virt && dec_exc_i && !keys_r[KEY_DECX]
         && !int_exc_i && !fp_exc_i) |=> !fault_o && keys_r[KEY_ERR];
    endproperty
    a_dec_flag: assert property (p_dec_flag) else $error("dec exception wrong");

    property p_px_bits;
        @(posedge clk_i) disable iff (!nrst_i)
        (ce_i && !px_write_i) |=> $stable(keys_r[1:0]) && $stable(active_register_set_o);
    endproperty
    a_px_bits: assert property (p_px_bits) else $error("exchange bits changed");

    property p_link;
        @(posedge clk_i) disable iff (!nrst_i)
        (ce_i && result_valid_i && !result_is_skip_op_i)
        |=> keys_r[KEY_LINK] == $past(result_carry_i);
    endproperty
    a_link: assert property (p_link) else $error("link not loaded");

    property p_skip_link;
        @(posedge clk_i) disable iff (!nrst_i)
        (ce_i && result_valid_i && result_is_skip_op_i && !load_status_word_op_i
         && !acc_to_keys_op_i && !output_keys_op_i) |=> $stable(keys_r[KEY_LINK]);
    endproperty
    a_skip_link: assert property (p_skip_link) else $error("skip op moved link");

    property p_zero_neg;
        @(posedge clk_i) disable iff (!nrst_i)
        (ce_i && result_valid_i && is_virt && !load_status_word_op_i
         && keys_nxt[KEY_MODE_H:KEY_MODE_L] == VIRTUAL64_MODE)
        |=> keys_r[KEY_ZERO] == $past(result_zero_i)
            && keys_r[KEY_NEG] == $past(result_ext_sign_i);
    endproperty
    a_zero_neg: assert property (p_zero_neg) else $error("condition codes wrong");

    property p_reserved;
        @(posedge clk_i) disable iff (!nrst_i)
        (modals_r[13:8] == 6'h00) && (!is_virt || (keys_r[4:2] == 3'h0 && !keys_r[14]));
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

endmodule : swfd_status_word

// ---- swfd_pkg.sv ----
package swfd_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int AP_W   = 32;

    // ------------------------------------------------------------
    // Keys field positions (bit 1 is the most significant bit)
    // ------------------------------------------------------------
    localparam int KEY_ERR    = 15;  // Arithmetic error flag, bit 1
    localparam int KEY_PREC   = 14;  // Precision select, bit 2
    localparam int KEY_LINK   = 13;  // Link, bit 3
    localparam int KEY_MODE_H = 12;  // Mode, bits 4-6
    localparam int KEY_MODE_L = 10;
    localparam int KEY_FPX    = 9;   // Bit 7
    localparam int KEY_INTX   = 8;   // Bit 8
    localparam int KEY_NEG    = 7;   // Bit 9
    localparam int KEY_ZERO   = 6;   // Bit 10
    localparam int KEY_DECX   = 5;   // Bit 11
    localparam int KEY_DISP   = 1;   // Bit 15
    localparam int KEY_SAVED  = 0;   // Bit 16

    // Writable keys bits, virtual and sector/relative layouts
    localparam logic [15:0] KEYS_V_WMASK  = 16'hBFE0;
    localparam logic [15:0] KEYS_SR_WMASK = 16'hFC00;
    localparam logic [15:0] KEYS_V_PX     = 16'h0003;

    // ------------------------------------------------------------
    // Modals field positions
    // ------------------------------------------------------------
    localparam int MOD_IEN    = 15;
    localparam int MOD_VEC    = 14;
    localparam int MOD_RSET_H = 7;   // Bits 9-11
    localparam int MOD_RSET_L = 5;
    localparam int MOD_MIO    = 4;
    localparam int MOD_PX     = 3;
    localparam int MOD_SEG    = 2;
    localparam int MOD_MCK_H  = 1;
    localparam int MOD_MCK_L  = 0;
    localparam logic [15:0] MODALS_WMASK = 16'hC01F;
    localparam logic [15:0] MODALS_PX    = 16'h00E0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] KEYS_RST   = 16'h0000;
    localparam logic [15:0] MODALS_RST = 16'h0000;

    // ------------------------------------------------------------
    // Addressing modes
    // ------------------------------------------------------------
    localparam logic [2:0] SECTOR16_MODE   = 3'h0;
    localparam logic [2:0] SECTOR32_MODE   = 3'h1;
    localparam logic [2:0] RELATIVE32_MODE = 3'h3;
    localparam logic [2:0] RELATIVE64_MODE = 3'h2;
    localparam logic [2:0] VIRTUAL64_MODE  = 3'h6;
    localparam logic [2:0] GENERAL_REG_MODE = 3'h4;

    // ------------------------------------------------------------
    // Instruction formats
    // ------------------------------------------------------------
    localparam logic [3:0] IO_MARK     = 4'hC;
    localparam logic [3:0] GENERIC_MID = 4'h0;

    typedef enum logic [2:0] {
        FMT_GENERIC,
        FMT_SHIFT,
        FMT_IO,
        FMT_DECIMAL,
        FMT_CHARACTER,
        FMT_ADDR_PTR,
        FMT_BRANCH
    } swfd_fmt_type;

    typedef enum logic [1:0] {
        IO_CONTROL,
        IO_SENSE,
        IO_INPUT,
        IO_OUTPUT
    } swfd_io_class_type;

endpackage : swfd_pkg

// ---- swfd_format_decode.sv ----
`timescale 1ns/1ns
module swfd_format_decode
    import swfd_pkg::*;
(
    input  wire logic                      clk_i,
    input  wire logic                      nrst_i,
    input  wire logic                      ce_i,
    input  wire logic                      load_i,
    input  wire swfd_pkg::swfd_fmt_type    fmt_i,
    input  wire logic [15:0]               word1_i,
    input  wire logic [31:0]               ext_i,
    input  wire logic [15:0]               proc_base_i,
    output logic      [15:0]               opcode_o,
    output logic      [5:0]                shift_count_o,
    output swfd_pkg::swfd_io_class_type    io_class_o,
    output logic      [3:0]                io_function_o,
    output logic      [5:0]                io_device_o,
    output logic      [31:0]               address_pointer_field_o,
    output logic      [15:0]               branch_target_o,
    output logic                           uses_field_regs_o,
    output logic                           uses_control_word_o,
    output logic                           format_error_o
);
    logic [15:0]        opcode_r,  opcode_nxt;
    logic [5:0]         shift_r,   shift_nxt;
    swfd_io_class_type  cls_r,     cls_nxt;
    logic [3:0]         func_r,    func_nxt;
    logic [5:0]         dev_r,     dev_nxt;
    logic [31:0]        ap_r,      ap_nxt;
    logic [15:0]        br_r,      br_nxt;
    logic               fld_r,     fld_nxt;
    logic               ctl_r,     ctl_nxt;
    logic               err_r,     err_nxt;
    logic [15:0]        word_offset_field;

    assign word_offset_field = ext_i[31:16];

    always_comb
    begin
        opcode_nxt = opcode_r;
        shift_nxt  = shift_r;
        cls_nxt    = cls_r;
        func_nxt   = func_r;
        dev_nxt    = dev_r;
        ap_nxt     = ap_r;
        br_nxt     = br_r;
        fld_nxt    = fld_r;
        ctl_nxt    = ctl_r;
        err_nxt    = err_r;
        if (load_i)
        begin
            opcode_nxt = word1_i;
            shift_nxt  = 6'h00;
            fld_nxt    = 1'b0;
            ctl_nxt    = 1'b0;
            err_nxt    = 1'b0;
            case (fmt_i)
                FMT_GENERIC:
                    err_nxt = (word1_i[13:10] != GENERIC_MID);
                FMT_SHIFT:
                begin
                    opcode_nxt = {word1_i[15:6], 6'h00};
                    shift_nxt  = 6'(~word1_i[5:0] + 6'h01);
                    err_nxt    = (word1_i[13:10] != GENERIC_MID);
                end
                FMT_IO:
                begin
                    cls_nxt  = swfd_io_class_type'(word1_i[15:14]);
                    func_nxt = word1_i[9:6];
                    dev_nxt  = word1_i[5:0];
                    err_nxt  = (word1_i[13:10] != IO_MARK);
                end
                FMT_DECIMAL:
                begin
                    fld_nxt = 1'b1;
                    ctl_nxt = 1'b1;
                end
                FMT_CHARACTER:
                    fld_nxt = 1'b1;
                FMT_ADDR_PTR:
                    ap_nxt = ext_i;
                FMT_BRANCH:
                    br_nxt = 16'(proc_base_i + word_offset_field);
                default:
                    err_nxt = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            opcode_r <= 16'h0000;
            shift_r  <= 6'h00;
            cls_r    <= IO_CONTROL;
            func_r   <= 4'h0;
            dev_r    <= 6'h00;
            ap_r     <= 32'h0000_0000;
            br_r     <= 16'h0000;
            fld_r    <= 1'b0;
            ctl_r    <= 1'b0;
            err_r    <= 1'b0;
        end
        else if (ce_i)
        begin
            opcode_r <= opcode_nxt;
            shift_r  <= shift_nxt;
            cls_r    <= cls_nxt;
            func_r   <= func_nxt;
            dev_r    <= dev_nxt;
            ap_r     <= ap_nxt;
            br_r     <= br_nxt;
            fld_r    <= fld_nxt;
            ctl_r    <= ctl_nxt;
            err_r    <= err_nxt;
        end
    end

    assign opcode_o                = opcode_r;
    assign shift_count_o           = shift_r;
    assign io_class_o              = cls_r;
    assign io_function_o           = func_r;
    assign io_device_o             = dev_r;
    assign address_pointer_field_o = ap_r;
    assign branch_target_o         = br_r;
    assign uses_field_regs_o       = fld_r;
    assign uses_control_word_o     = ctl_r;
    assign format_error_o          = err_r;

endmodule : swfd_format_decode

// ---- swfd_status_word_bench.sv ----
`timescale 1ns/1ns
module swfd_status_word_bench;
    import swfd_pkg::*;
    logic               clk_i = 1'h0, nrst_i = 1'h0, ce_i = 1'h1;
    logic               lsw = 1'h0, tak_op = 1'h0, otk_op = 1'h0, tka_op = 1'h0, pxw = 1'h0;
    logic               pxd = 1'h0, pxs = 1'h0, rv = 1'h0, rskip = 1'h0, rc = 1'h0, rz = 1'h0;
    logic               rs = 1'h0, ae = 1'h0, fe = 1'h0, ie = 1'h0, de = 1'h0, dl = 1'h0;
    logic [31:0]        sd = 32'h0, dx = 32'h0, apf;
    logic [15:0]        acc = 16'h0, dw = 16'h0, pb = 16'h0, acck, keys, mods, opc, btgt;
    logic [2:0]         pxr = 3'h0, amode, rset;
    logic [5:0]         shc, iodev;
    logic [3:0]         iofn;
    logic               fault, vmode, prec, ien, ufr, ucw, ferr;
    swfd_fmt_type       df = FMT_GENERIC;
    swfd_io_class_type  iocls;
    int                 err_total = 0, cmp_count = 0;
    logic [2:0]         modes [6] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h4, 3'h6};

    swfd_status_word DUT (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
        .load_status_word_op_i(lsw), .status_data_i(sd), .acc_to_keys_op_i(tak_op),
        .output_keys_op_i(otk_op), .acc_i(acc), .keys_to_acc_op_i(tka_op), .acc_keys_o(acck),
        .px_write_i(pxw), .px_dispatcher_i(pxd), .px_save_done_i(pxs),
        .px_register_set_i(pxr), .result_valid_i(rv), .result_is_skip_op_i(rskip),
        .result_carry_i(rc), .result_zero_i(rz), .result_ext_sign_i(rs), .arith_error_i(ae),
        .fp_exc_i(fe), .int_exc_i(ie), .dec_exc_i(de), .fault_o(fault), .status_keys_o(keys),
        .processor_modals_o(mods), .addr_mode_o(amode), .virtual_mode_o(vmode),
        .precision_select_o(prec), .interrupt_enable_o(ien), .active_register_set_o(rset),
        .decode_load_i(dl), .decode_fmt_i(df), .decode_word_i(dw), .decode_ext_i(dx),
        .proc_base_i(pb), .opcode_o(opc), .shift_count_o(shc), .io_class_o(iocls),
        .io_function_o(iofn), .io_device_o(iodev), .address_pointer_field_o(apf),
        .branch_target_o(btgt), .uses_field_regs_o(ufr), .uses_control_word_o(ucw),
        .format_error_o(ferr));

    always #25 clk_i = ~clk_i;

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One-cycle strobe, launched and dropped at falling edges
    task automatic pulse(ref logic s);
        @(negedge clk_i);
        s = 1'h1;
        @(negedge clk_i);
        s = 1'h0;
    endtask : pulse

    task automatic dec(input swfd_fmt_type f, input logic [15:0] w, input logic [31:0] x);
        df = f;
        dw = w;
        dx = x;
        pulse(dl);
    endtask : dec

    task results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results

    initial
    begin
        #(3000 * 50);
        err_total++;
        results();
    end

    initial
    begin
        repeat (3) @(negedge clk_i);
        nrst_i = 1'h1;
        chk(keys, 16'h0000);
        chk(mods, 16'h0000);
        chk(amode, SECTOR16_MODE);
        pulse(ae);
        chk(keys, 16'h8000);
        $display("test reset done");
        acc = 16'hC3FF;
        pulse(tak_op);
        chk(keys, 16'hC000);
        chk(prec, 1'h1);
        for (int i = 0; i < 6; i++)
        begin
            acc = {3'h0, modes[i], 10'h000};
            if (i % 2 == 0) pulse(tak_op);
            else pulse(otk_op);
            chk(amode, modes[i]);
            chk(vmode, modes[i] == 3'h6);
        end
        $display("test modes done");
        acc = 16'hBBE3;
        pulse(tak_op);
        chk(keys, 16'hBBE0);
        pulse(tka_op);
        chk(acck, 16'hBBE0);
        pxd = 1'h1;
        pxs = 1'h1;
        pxr = 3'h5;
        pulse(pxw);
        chk(keys, 16'hBBE3);
        chk(rset, 3'h5);
        sd = {16'h581F, 16'hFFBF};
        pulse(lsw);
        chk(keys, 16'h1803);
        chk(mods, 16'hC0BF);
        chk(ien, 1'h1);
        $display("test status load done");
        {rc, rz, rs} = 3'h7;
        pulse(rv);
        chk(keys, 16'h38C3);
        {rskip, rc, rz, rs} = 4'h9;
        pulse(rv);
        chk(keys[KEY_LINK], 1'h1);
        chk(keys, 16'h3883);
        {rskip, rs} = 2'h0;
        pulse(rv);
        chk(keys, 16'h1803);
        $display("test condition codes done");
        pulse(fe);
        chk(fault, 1'h1);
        pulse(de);
        chk({fault, keys[KEY_ERR]}, 2'h1);
        acc = 16'h1803;
        pulse(tak_op);
        pulse(ie);
        chk(fault, 1'h0);
        chk(keys[KEY_ERR], 1'h1);
        acc = 16'h1B20;
        pulse(tak_op);
        chk(keys, 16'h1B23);
        pulse(ie);
        chk(fault, 1'h1);
        pulse(de);
        chk(fault, 1'h1);
        pulse(fe);
        chk(fault, 1'h0);
        chk(keys[KEY_ERR], 1'h1);
        ce_i = 1'h0;
        pulse(tak_op);
        chk(keys, 16'h9B23);
        ce_i = 1'h1;
        $display("test exceptions done");
        dec(FMT_SHIFT, 16'h4003, 32'h0);
        chk({opc, shc, ferr}, {16'h4000, 6'h3D, 1'h0});
        for (int c = 0; c < 4; c++)
        begin
            dec(FMT_IO, {c[1:0], IO_MARK, 4'h5, 6'h2A}, 32'h0);
            chk({iocls, iofn, iodev, ferr}, {c[1:0], 4'h5, 6'h2A, 1'h0});
        end
        dec(FMT_IO, 16'hB56A, 32'h0);
        chk(ferr, 1'h1);
        dec(FMT_GENERIC, 16'h8003, 32'h0);
        chk({opc, ferr}, {16'h8003, 1'h0});
        dec(FMT_GENERIC, 16'h0400, 32'h0);
        chk(ferr, 1'h1);
        dec(FMT_DECIMAL, 16'h1234, 32'h0);
        chk({opc, ufr, ucw}, {16'h1234, 2'h3});
        dec(FMT_CHARACTER, 16'h1235, 32'h0);
        chk({opc, ufr, ucw}, {16'h1235, 2'h2});
        dec(FMT_ADDR_PTR, 16'h0011, 32'h1234_5678);
        chk(apf, 32'h1234_5678);
        pb = 16'hFFF0;
        dec(FMT_BRANCH, 16'h0022, 32'h0020_0000);
        chk(btgt, 16'h0010);
        $display("test decode done");
        results();
    end
endmodule : swfd_status_word_bench
